// >>> orupb_top.sv
// Contract
// - channels decoded from one relocatable base
// - eight channels, eight byte registers each; only offsets 0 to 5 implemented, 6 and 7 read zero
// - offset 64 reports pending channel interrupts
// - readable 16-bit vendor and device codes
// - latch bit redirects offsets 0,1 to divisor
// - offset 0 low, offset 1 high divisor
// - reference divided by divisor times sixteen
// - 1.8432 MHz reference, eight-times rate option
// - character length is field plus five
// - bit 2 chooses one or two stops
// - status bit 0 flags received data
// - identification value 4 means received data
// - status bit 5 flags holding register empty
// - automatic mode enables driver when sending
`timescale 1ns/10ps
`default_nettype none

module orupb_chan (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register access
  input wire logic [2:0] reg_sel,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // shared timing and mode
  input wire logic ref_tick,
  input wire logic auto_en,
  // line pins
  input wire logic line_in,
  output logic line_out_r,
  output logic line_oe_n_r,
  output logic pending
);
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001, TX_START = 4'b0010,
    TX_DATA = 4'b0100, TX_STOP = 4'b1000
  } orupb_tx_type;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010,
    RX_DATA = 4'b0100, RX_STOP = 4'b1000
  } orupb_rx_type;

  logic [15:0] div_r, div_cnt_r;
  logic [7:0] lcr_r, ier_r, mcr_r, thr_r, rbr_r, tx_sh_r, rx_sh_r;
  logic thr_full_r, dr_r, oe_r, fe_r, os_tick;
  logic rx_m_r, rx_s_r;
  orupb_tx_type tx_st_r;
  orupb_rx_type rx_st_r;
  logic [3:0] tx_os_r, rx_os_r;
  logic [2:0] tx_bit_r, rx_bit_r, last_bit;
  logic tx_stop_r, rx_done, rx_ok;
  logic divisor_access_latch_bit, wr_data, rd_data, rd_lsr, tx_load, tx_end;
  logic [15:0] div_eff;
  logic [7:0] lsr, iir;

  // register decode; latch bit steers offsets 0 and 1
  assign divisor_access_latch_bit = lcr_r[orupb_pkg::LCR_DIVISOR_ACCESS_LATCH_BIT];
  assign wr_data = wr && reg_sel == orupb_pkg::OFF_DATA && !divisor_access_latch_bit;
  assign rd_data = rd && reg_sel == orupb_pkg::OFF_DATA && !divisor_access_latch_bit;
  assign rd_lsr = rd && reg_sel == orupb_pkg::OFF_LSR;
  assign last_bit = lcr_r[2:0] & 3'h3 | orupb_pkg::LEN_BASE;
  assign lsr = {1'b0, !thr_full_r && tx_st_r == TX_IDLE, !thr_full_r,
    1'b0, fe_r, 1'b0, oe_r, dr_r};
  assign iir = (ier_r[orupb_pkg::IER_RX] && dr_r) ? orupb_pkg::IIR_RX :
    (ier_r[orupb_pkg::IER_TX] && !thr_full_r) ? orupb_pkg::IIR_TX :
    orupb_pkg::IIR_NONE;
  assign pending = !iir[0];
  always_comb begin
    unique case (reg_sel)
      orupb_pkg::OFF_DATA: rdata = divisor_access_latch_bit ? div_r[7:0] : rbr_r;
      orupb_pkg::OFF_IER: rdata = divisor_access_latch_bit ? div_r[15:8] : ier_r;
      orupb_pkg::OFF_IIR: rdata = iir;
      orupb_pkg::OFF_LCR: rdata = lcr_r;
      orupb_pkg::OFF_MCR: rdata = mcr_r;
      orupb_pkg::OFF_LSR: rdata = lsr;
      default: rdata = 8'h00;
    endcase
  end

  // control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= orupb_pkg::DIV_RST;
      lcr_r <= orupb_pkg::LCR_RST;
      ier_r <= orupb_pkg::ZERO_RST;
      mcr_r <= orupb_pkg::ZERO_RST;
    end else if (wr) begin
      if (reg_sel == orupb_pkg::OFF_DATA && divisor_access_latch_bit) div_r[7:0] <= wdata;
      if (reg_sel == orupb_pkg::OFF_IER && divisor_access_latch_bit) div_r[15:8] <= wdata;
      if (reg_sel == orupb_pkg::OFF_IER && !divisor_access_latch_bit) ier_r <= wdata;
      if (reg_sel == orupb_pkg::OFF_LCR) lcr_r <= wdata;
      if (reg_sel == orupb_pkg::OFF_MCR) mcr_r <= wdata;
    end
  end

  // oversample tick: divisor of zero behaves as one
  assign div_eff = (div_r == 16'h0000) ? 16'h0001 : div_r;
  assign os_tick = ref_tick && div_cnt_r >= div_eff - 16'h0001;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) div_cnt_r <= 16'h0000;
    else if (os_tick) div_cnt_r <= 16'h0000;
    else if (ref_tick) div_cnt_r <= div_cnt_r + 16'h0001;
  end

  // transmitter; no start while the latch bit hides the data port
  assign tx_load = tx_st_r == TX_IDLE && thr_full_r && !divisor_access_latch_bit;
  assign tx_end = os_tick && tx_os_r == orupb_pkg::OS_LAST;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) thr_full_r <= 1'b0;
    else if (wr_data) thr_full_r <= 1'b1;
    else if (tx_load) thr_full_r <= 1'b0;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) thr_r <= 8'h00;
    else if (wr_data) thr_r <= wdata;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_r <= TX_IDLE;
      tx_os_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_stop_r <= 1'b0;
      tx_sh_r <= 8'h00;
      line_out_r <= 1'b1;
    end else begin
      if (os_tick) tx_os_r <= tx_os_r + 4'h1;
      unique case (tx_st_r)
        TX_IDLE: if (tx_load) begin
          tx_sh_r <= thr_r;
          tx_os_r <= 4'h0;
          line_out_r <= 1'b0;
          tx_st_r <= TX_START;
        end
        TX_START: if (tx_end) begin
          line_out_r <= tx_sh_r[0];
          tx_sh_r <= {1'b0, tx_sh_r[7:1]};
          tx_bit_r <= 3'h0;
          tx_st_r <= TX_DATA;
        end
        TX_DATA: if (tx_end) begin
          if (tx_bit_r == last_bit) begin
            line_out_r <= 1'b1;
            tx_stop_r <= lcr_r[orupb_pkg::LCR_STOP2];
            tx_st_r <= TX_STOP;
          end else begin
            line_out_r <= tx_sh_r[0];
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            tx_bit_r <= tx_bit_r + 3'h1;
          end
        end
        TX_STOP: if (tx_end) begin
          if (tx_stop_r) tx_stop_r <= 1'b0;
          else tx_st_r <= TX_IDLE;
        end
      endcase
    end
  end

  // driver enable; auto mode covers queued data and the final stop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) line_oe_n_r <= 1'b1;
    else if (auto_en)
      line_oe_n_r <= !(thr_full_r || tx_st_r != TX_IDLE);
    else line_oe_n_r <= !mcr_r[orupb_pkg::MCR_RTS];
  end

  // receiver line synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
    end else begin
      rx_m_r <= line_in;
      rx_s_r <= rx_m_r;
    end
  end

  // receiver samples mid-bit; start glitches abort
  assign rx_done = rx_st_r == RX_STOP && os_tick &&
    rx_os_r == orupb_pkg::OS_LAST;
  assign rx_ok = os_tick && rx_os_r == orupb_pkg::OS_LAST;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_st_r <= RX_IDLE;
      rx_os_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
    end else begin
      if (os_tick) rx_os_r <= rx_os_r + 4'h1;
      unique case (rx_st_r)
        RX_IDLE: if (!rx_s_r && !divisor_access_latch_bit) begin
          rx_os_r <= 4'h0;
          rx_st_r <= RX_START;
        end
        RX_START: if (os_tick && rx_os_r == orupb_pkg::OS_MID) begin
          rx_os_r <= 4'h0;
          rx_bit_r <= 3'h0;
          rx_sh_r <= 8'h00;
          rx_st_r <= rx_s_r ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_ok) begin
          rx_sh_r[rx_bit_r] <= rx_s_r;
          rx_bit_r <= rx_bit_r + 3'h1;
          if (rx_bit_r == last_bit) rx_st_r <= RX_STOP;
        end
        RX_STOP: if (rx_ok) rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // receive buffer and status; a new character beats the clearing read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rbr_r <= 8'h00;
      dr_r <= 1'b0;
      oe_r <= 1'b0;
      fe_r <= 1'b0;
    end else begin
      if (rx_done) rbr_r <= rx_sh_r;
      dr_r <= rx_done || (dr_r && !rd_data);
      oe_r <= (rx_done && dr_r && !rd_data) || (oe_r && !rd_lsr);
      fe_r <= (rx_done && !rx_s_r) || (fe_r && !rd_lsr);
    end
  end

  dr_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    rx_done |=> dr_r && rbr_r == $past(rx_sh_r))
    else $error("received character not flagged");
  dr_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    rd_data && !rx_done |=> !dr_r)
    else $error("data ready not cleared by read");
  thre_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_data |=> !lsr[5] ##0 thr_r == $past(wdata))
    else $error("holding empty flag wrong after write");
  iir_rx_a: assert property (@(posedge clk) disable iff (!reset_n)
    ier_r[orupb_pkg::IER_RX] && dr_r |-> rdata == 8'h04 ||
      reg_sel != orupb_pkg::OFF_IIR)
    else $error("identification not showing received data");
  div_hide_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr && divisor_access_latch_bit && reg_sel == orupb_pkg::OFF_DATA |=>
      div_r[7:0] == $past(wdata) && $stable(thr_r))
    else $error("divisor write reached data port");
  auto_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
    (auto_en && tx_st_r == TX_STOP) [*2] |-> !line_oe_n_r)
    else $error("driver released during stop bit");
  manual_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
    !auto_en |=> line_oe_n_r == !$past(mcr_r[orupb_pkg::MCR_RTS]))
    else $error("driver does not follow request bit");
endmodule

module orupb_top #(
  parameter logic [15:0] VENDOR_ID = orupb_pkg::VENDOR_CODE,
  parameter logic [15:0] DEVICE_ID = orupb_pkg::DEVICE_CODE
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // host i/o port
  input wire logic [15:0] cfg_base,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_r,
  output logic io_rvalid_r,
  // identity
  output logic [15:0] cfg_vendor_id_r,
  output logic [15:0] cfg_device_id_r,
  // mode pins
  input wire logic auto_mode,
  input wire logic fast_clock_sel,
  // line pins, channel 0 is first_serial_channel
  input wire logic [7:0] line_in,
  output logic [7:0] line_out,
  output logic [7:0] line_oe_n
);
  logic [15:0] off;
  logic hit, hit_chan, hit_sum;
  logic [7:0] pend;
  logic [7:0] chan_rdata [8];
  logic [7:0] rd_mux;
  logic [19:0] acc_r, acc_step, acc_sum;
  logic ref_tick_r;
  logic auto_m_r, auto_s_r, fast_m_r, fast_s_r;

  // relocatable decode against host-assigned base
  assign off = io_addr - cfg_base;
  assign hit = off < orupb_pkg::REGION_SIZE;
  assign hit_chan = hit && off < orupb_pkg::SUMMARY_OFF;
  assign hit_sum = hit && off == orupb_pkg::SUMMARY_OFF;
  assign rd_mux = hit_sum ? pend : hit_chan ? chan_rdata[off[5:3]] : 8'h00;

  // mode pin synchronisers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      auto_m_r <= 1'b0;
      auto_s_r <= 1'b0;
      fast_m_r <= 1'b0;
      fast_s_r <= 1'b0;
    end else begin
      auto_m_r <= auto_mode;
      auto_s_r <= auto_m_r;
      fast_m_r <= fast_clock_sel;
      fast_s_r <= fast_m_r;
    end
  end

  // fractional reference tick, jitter one system clock
  assign acc_step = fast_s_r ? orupb_pkg::ACC_STEP_X8 :
    orupb_pkg::ACC_STEP_X1;
  assign acc_sum = acc_r + acc_step;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= 20'h00000;
      ref_tick_r <= 1'b0;
    end else begin
      ref_tick_r <= acc_sum >= orupb_pkg::ACC_MOD_W;
      acc_r <= (acc_sum >= orupb_pkg::ACC_MOD_W) ?
        acc_sum - orupb_pkg::ACC_MOD_W : acc_sum;
    end
  end

  // host read return and identity
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata_r <= 8'h00;
      io_rvalid_r <= 1'b0;
      cfg_vendor_id_r <= VENDOR_ID;
      cfg_device_id_r <= DEVICE_ID;
    end else begin
      io_rdata_r <= io_rd ? rd_mux : 8'h00;
      io_rvalid_r <= io_rd;
    end
  end

  for (genvar i = 0; i < orupb_pkg::CHANNELS; i++) begin : g_chan
    orupb_chan u_chan (
      .clk(clk),
      .reset_n(reset_n),
      .reg_sel(off[2:0]),
      .wr(io_wr && hit_chan && off[5:3] == 3'(i)),
      .rd(io_rd && hit_chan && off[5:3] == 3'(i)),
      .wdata(io_wdata),
      .rdata(chan_rdata[i]),
      .ref_tick(ref_tick_r),
      .auto_en(auto_s_r),
      .line_in(line_in[i]),
      .line_out_r(line_out[i]),
      .line_oe_n_r(line_oe_n[i]),
      .pending(pend[i])
    );
  end

  summary_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    io_rd && hit_sum |=> io_rvalid_r && io_rdata_r == $past(pend))
    else $error("summary read returned wrong value");
  ref_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
    ref_tick_r && !fast_s_r |=> !ref_tick_r [*8])
    else $error("reference tick too fast");
endmodule
`default_nettype wire

// >>> orupb_pkg.sv
package orupb_pkg;
  // clocking
  localparam int SYS_HZ = 50000000;
  localparam int REF_HZ = 1843200;
  localparam int FAST_MULT = 8;
  localparam int PRESCALE = 16;
  localparam int ACC_MOD = SYS_HZ / 100;
  localparam int ACC_STEP = REF_HZ / 100;
  localparam logic [19:0] ACC_MOD_W = 20'(ACC_MOD);
  localparam logic [19:0] ACC_STEP_X1 = 20'(ACC_STEP);
  localparam logic [19:0] ACC_STEP_X8 = 20'(ACC_STEP * FAST_MULT);
  localparam logic [3:0] OS_LAST = 4'(PRESCALE - 1);
  localparam logic [3:0] OS_MID = 4'(PRESCALE / 2 - 1);
  // address map
  localparam int CHANNELS = 8;
  localparam logic [15:0] SUMMARY_OFF = 16'h0040;
  localparam logic [15:0] REGION_SIZE = 16'h0041;
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_IER = 3'h1;
  localparam logic [2:0] OFF_IIR = 3'h2;
  localparam logic [2:0] OFF_LCR = 3'h3;
  localparam logic [2:0] OFF_MCR = 3'h4;
  localparam logic [2:0] OFF_LSR = 3'h5;
  // fields
  localparam int LCR_DIVISOR_ACCESS_LATCH_BIT = 7;
  localparam int LCR_STOP2 = 2;
  localparam int MCR_RTS = 1;
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam logic [7:0] IIR_NONE = 8'h01;
  localparam logic [7:0] IIR_TX = 8'h02;
  localparam logic [7:0] IIR_RX = 8'h04;
  localparam logic [2:0] LEN_BASE = 3'h4;
  // reset values
  localparam logic [15:0] DIV_RST = 16'h000C;
  localparam logic [7:0] LCR_RST = 8'h03;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // identity, values arbitrary
  localparam logic [15:0] VENDOR_CODE = 16'hA5A5;
  localparam logic [15:0] DEVICE_CODE = 16'h0808;
endpackage

// >>> orupb_remote.sv
`timescale 1ns/10ps
`default_nettype none

module orupb_remote (
  // far end of the eight pairs
  input wire logic [7:0] line_out,
  input wire logic [7:0] line_oe_n,
  output logic [7:0] line_in
);
  // idle pairs sit high through the bias network
  initial line_in = 8'hFF;

  // one inbound frame: eight data bits, one stop
  task automatic send(input int ch, input real bt, input logic [7:0] d);
    line_in[ch] = 1'b0;
    #(bt);
    for (int i = 0; i < 8; i++) begin
      line_in[ch] = d[i];
      #(bt);
    end
    line_in[ch] = 1'b1;
    #(bt);
  endtask

  // mid-bit sampling; ok drops on a bad start, stop or enable
  task automatic recv(input int ch, input real bt, input int len,
    input int stops, output logic [7:0] d, output logic ok);
    d = 8'h00;
    // polled so that an automatic index never sits in an event
    while (line_out[ch] !== 1'b0) #1;
    #(bt / 2);
    ok = (line_out[ch] === 1'b0) && (line_oe_n[ch] === 1'b0);
    for (int i = 0; i < len; i++) begin
      #(bt);
      d[i] = line_out[ch];
    end
    for (int s = 0; s < stops; s++) begin
      #(bt);
      ok = ok && (line_out[ch] === 1'b1) && (line_oe_n[ch] === 1'b0);
    end
  endtask
endmodule

`default_nettype wire

// >>> tb_octal_rs485_uart_port_block.sv
`timescale 1ns/10ps
`default_nettype none

module tb_octal_rs485_uart_port_block;
  // bit time at divisor 1 with the eight-times reference
  localparam real BT1 = 1.0e9 * orupb_pkg::PRESCALE /
    (orupb_pkg::REF_HZ * orupb_pkg::FAST_MULT);
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] cfg_base = 16'hFC00;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic auto_mode = 1'b1;
  logic fast_clock_sel = 1'b1;
  logic [7:0] io_rdata_r;
  logic io_rvalid_r;
  logic [15:0] vendor_id;
  logic [15:0] device_id;
  logic [7:0] line_in;
  logic [7:0] line_out;
  logic [7:0] line_oe_n;
  int fails = 0;
  int checked = 0;
  logic [7:0] rv;
  logic [7:0] d;
  logic ok;

  // 50 MHz
  always #10 clk = ~clk;

  orupb_top dut_u (.clk(clk), .reset_n(reset_n), .cfg_base(cfg_base),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata_r(io_rdata_r), .io_rvalid_r(io_rvalid_r),
    .cfg_vendor_id_r(vendor_id), .cfg_device_id_r(device_id),
    .auto_mode(auto_mode), .fast_clock_sel(fast_clock_sel),
    .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n));

  orupb_remote far_u (.line_out(line_out), .line_oe_n(line_oe_n),
    .line_in(line_in));

  task automatic check_val(input string what, input logic [15:0] seen,
    input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // strobes rise and fall on falling edges, one edge takes them
  task automatic wr(input logic [6:0] off, input logic [7:0] v);
    @(negedge clk);
    io_addr = cfg_base + 16'(off);
    io_wdata = v;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask

  // read answer stands one cycle, so take it at the first falling edge
  task automatic rd(input logic [6:0] off, output logic [7:0] v);
    @(negedge clk);
    io_addr = cfg_base + 16'(off);
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    v = io_rdata_r;
    check_val("read valid", 16'(io_rvalid_r), 16'h0001);
  endtask

  task automatic rdc(input string what, input logic [6:0] off,
    input logic [7:0] want);
    rd(off, rv);
    check_val(what, 16'(rv), 16'(want));
  endtask

  // start-up as a host does it: divisor, 8N1, flush
  task automatic init_chan(input int ch, input logic [7:0] dv);
    logic [6:0] b;
    b = 7'(ch * 8);
    wr(b + 7'h3, 8'h80);
    wr(b, dv);
    wr(b + 7'h1, 8'h00);
    wr(b + 7'h3, 8'h03);
    rd(b, rv);
    rd(b, rv);
  endtask

  task automatic t_reset();
    check_val("vendor", vendor_id, orupb_pkg::VENDOR_CODE);
    check_val("device", device_id, orupb_pkg::DEVICE_CODE);
    rdc("lcr", 7'h03, orupb_pkg::LCR_RST);
    rdc("ident idle", 7'h02, orupb_pkg::IIR_NONE);
    rdc("status", 7'h05, 8'h60);
    rdc("summary idle", 7'h40, 8'h00);
    rdc("unmapped", 7'h41, 8'h00);
    wr(7'h03, 8'h83);
    rdc("div low", 7'h00, orupb_pkg::DIV_RST[7:0]);
    rdc("div high", 7'h01, orupb_pkg::DIV_RST[15:8]);
    wr(7'h01, 8'h5A);
    wr(7'h03, 8'h03);
    rdc("ier hidden", 7'h01, 8'h00);
    wr(7'h03, 8'h83);
    rdc("div kept", 7'h01, 8'h5A);
    wr(7'h01, 8'h00);
    wr(7'h03, 8'h03);
  endtask

  // second byte waits in the holding register behind the first
  task automatic t_tx();
    logic [7:0] d2;
    logic ok2;
    init_chan(0, 8'h01);
    fork
      begin
        far_u.recv(0, BT1, 8, 1, d, ok);
        far_u.recv(0, BT1, 8, 1, d2, ok2);
      end
      begin
        wr(7'h00, 8'hA5);
        rv = 8'h00;
        for (int i = 0; i < 20 && !rv[5]; i++) rd(7'h05, rv);
        wr(7'h00, 8'h3C);
        rdc("holding full", 7'h05, 8'h00);
      end
    join
    check_val("byte one", 16'(d), 16'h00A5);
    check_val("frame one", 16'(ok), 16'h0001);
    check_val("byte two", 16'(d2), 16'h003C);
    check_val("frame two", 16'(ok2), 16'h0001);
    #(BT1);
    check_val("released", 16'(line_oe_n[0]), 16'h0001);
    rdc("all sent", 7'h05, 8'h60);
  endtask

  // every length code, stop count from the low code bit, divisor 2
  task automatic t_len();
    init_chan(1, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(7'h0B, 8'(c) | (c[0] ? 8'h04 : 8'h00));
      fork
        far_u.recv(1, 2.0 * BT1, c + 5, 1 + c % 2, d, ok);
        wr(7'h08, 8'h96);
      join
      // let the last stop finish before the format changes
      #(2.0 * BT1);
      check_val("short byte", 16'(d), 16'(8'h96 & (8'hFF >> (3 - c))));
      check_val("stops", 16'(ok), 16'h0001);
      check_val("idle drv", 16'(line_oe_n[1]), 16'h0001);
    end
  endtask

  task automatic t_manual();
    @(negedge clk);
    auto_mode = 1'b0;
    rd(7'h14, rv);
    wr(7'h14, rv | 8'h02);
    repeat (2) @(negedge clk);
    check_val("drv on", 16'(line_oe_n), 16'h00FB);
    wr(7'h14, rv & 8'hFD);
    repeat (2) @(negedge clk);
    check_val("drv off", 16'(line_oe_n), 16'h00FF);
    auto_mode = 1'b1;
  endtask

  // handler order: ident, then data only when flagged
  task automatic t_rx();
    init_chan(3, 8'h01);
    wr(7'h19, 8'h01);
    far_u.send(3, BT1, 8'hC3);
    rv = 8'h00;
    for (int i = 0; i < 20 && !rv[0]; i++) rd(7'h1D, rv);
    check_val("ready", 16'(rv[0]), 16'h0001);
    rdc("ident rx", 7'h1A, orupb_pkg::IIR_RX);
    rdc("summary", 7'h40, 8'h08);
    rdc("data", 7'h18, 8'hC3);
    rdc("ready clear", 7'h1D, 8'h60);
    rdc("ident none", 7'h1A, orupb_pkg::IIR_NONE);
    rdc("summary clear", 7'h40, 8'h00);
    wr(7'h19, 8'h02);
    rdc("ident tx", 7'h1A, orupb_pkg::IIR_TX);
    rdc("summary tx", 7'h40, 8'h08);
    wr(7'h19, 8'h00);
  endtask

  // 9600 on the normal reference: divisor 0x0C, short frame keeps it brief
  task automatic t_slow();
    @(negedge clk);
    fast_clock_sel = 1'b0;
    init_chan(4, 8'h0C);
    wr(7'h23, 8'h00);
    fork
      far_u.recv(4, BT1 * 96.0, 5, 1, d, ok);
      wr(7'h20, 8'h15);
    join
    check_val("slow byte", 16'(d), 16'h0015);
    check_val("slow frame", 16'(ok), 16'h0001);
  endtask

  task automatic t_map();
    for (int c = 0; c < 8; c++) wr(7'(c * 8 + 3), 8'(c));
    for (int c = 0; c < 8; c++) rdc("lcr map", 7'(c * 8 + 3), 8'(c));
    cfg_base = 16'h1230;
    rdc("moved base", 7'h3B, 8'h07);
  endtask

  // reset, scenarios, verdict
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_tx();
    t_len();
    t_manual();
    t_rx();
    t_map();
    t_slow();
    stop_test();
  end

  // the run needs about 0.8 ms; a hang is cut at 1.6 ms
  initial begin
    #1600000;
    fails++;
    stop_test();
  end
endmodule

`default_nettype wire
